// ---- design/cpx_cfg.svh ----
`ifndef CPX_CFG_SVH
`define CPX_CFG_SVH
// ----------------------------------
// register byte offsets
// ----------------------------------
`define OF_INSTR 8'h00
`define OF_PC 8'h04
`define OF_STAT 8'h08
`define OF_OPND 8'h0C
`define OF_BASE 8'h10
`define OF_SHCNT 8'h14
`define OF_IMM 8'h18
`define OF_RES 8'h1C
`define OF_CTRL 8'h20
// ----------------------------------
// opcodes, instruction bit 15 is msb
// ----------------------------------
`define OPC_LSF 6'h0C
`define OPC_SSF 6'h0D
`define OPC_BSET 8'h1D
`define OPC_BCLR 8'h1E
`define OPC_BTST 8'h1F
`define OPC_JUMP 4'h1
`define OPC_SHRA 8'h08
`define OPC_SHRL 8'h09
`define OPC_SHL 8'h0A
`define OPC_ROR 8'h0B
`define OPC_ILD 11'h010
`define OPC_IADD 11'h011
`define OPC_IAND 11'h012
`define OPC_IOR 11'h013
`define OPC_ICMP 11'h014
// ----------------------------------
// jump condition codes
// ----------------------------------
`define J_ALW 4'h0
`define J_LT 4'h1
`define J_LE 4'h2
`define J_EQ 4'h3
`define J_HE 4'h4
`define J_GT 4'h5
`define J_NE 4'h6
`define J_NC 4'h7
`define J_OC 4'h8
`define J_NO 4'h9
`define J_L 4'hA
`define J_H 4'hB
`define J_OP 4'hC
// ----------------------------------
// fields and counts
// ----------------------------------
`define F_OP4 15:12
`define F_OP6 15:10
`define F_OP8 15:8
`define F_OP11 15:5
`define F_JC 11:8
`define F_SCNT 9:6
`define F_SHCNT 7:4
`define F_TS 5:4
`define F_DISP 7:0
`define F_SHN 3:0
`define F_BASE 12:1
`define F_ST 15:10
`define F_ADDR 7:0
`define TS_AUTO 2'h3
`define FULL_CNT 5'h10
`define BYTE_MAX 5'h08
`define ONE_CNT 5'h01
`define WSTEP 16'h0002
`define ISTEP 16'h0004
`define INC_BYTE 2'h1
`define INC_WORD 2'h2
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`define ZERO16 16'h0000
`define ZERO8 8'h00
`endif

// ---- design/cpx_pkg.sv ----
package cpx_pkg;
  typedef struct packed {
    logic lgt;
    logic agt;
    logic eq;
    logic car;
    logic ovf;
    logic par;
  } cpx_flags_t;
  typedef struct packed {
    logic [11:0] addr;
    logic data;
    logic we;
  } cpx_sio_t;
  typedef enum logic [1:0] {
    CPX_IDLE = 2'b00,
    CPX_LOAD = 2'b01,
    CPX_RUN = 2'b11
  } cpx_state_t;
  typedef enum logic [3:0] {
    CPX_NONE, CPX_LSF, CPX_SSF, CPX_BSET, CPX_BCLR, CPX_BTST, CPX_JUMP, CPX_SHL,
    CPX_SHRA, CPX_ROR, CPX_SHRL, CPX_ILD, CPX_IADD, CPX_IAND, CPX_IOR, CPX_ICMP
  } cpx_op_t;
endpackage

// ---- design/cpx_exec.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cpx_cfg.svh"
// How it works
// - Multi-bit serial moves count-field bits; zero count moves sixteen.
// - Start serial address is base register bits 1 to 12.
// - One bit per cycle, serial address steps, base register untouched.
// - Counts 1-8 mark a byte source address, others a word address.
// - Auto-increment source steps by 1 for counts 1-8, else by 2.
// - Load field sends operand lsb first; sets compare flags and parity.
// - Store field fills result from lsb; unfilled bits are zero.
// - Bit set/clear drive base-relative output bit; flags untouched.
// - Bit test copies the addressed input bit into the equal flag.
// - Jump loads target only if condition holds, else next word.
// - Signed 8-bit word displacement added to address after the jump.
// - Compare-style jump conditions from equal and greater flags.
// - Single-flag jumps on carry, overflow, parity; one jump unconditional.
// - Shift count zero takes count register low nibble; zero means sixteen.
// - Left arithmetic shift fills zeros; updates compare, carry, overflow.
// - Right arithmetic shift refills msb; updates compare and carry.
// - Circular shift wraps lsb to msb; logical shift fills zeros.
// - Immediate load, add, and, or, compare; add also sets carry, overflow.
// - Serial parity set only for counts 1-8 with odd ones.
// - Shift carry is the last bit shifted out.
// - Left shift overflow if msb changes at any step.
module cpx_exec #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // bit serial io space
  output var cpx_pkg::cpx_sio_t o_sio,
  input wire logic i_sio_in,
  // core side
  output var cpx_pkg::cpx_flags_t o_flags,
  output logic o_busy,
  output logic o_src_byte,
  output logic [1:0] o_src_incr
);
  import cpx_pkg::*;

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
    $error("cpx_exec: ADDR_W must be 8 to 32");
  end

  // ----------------------------------
  // functions
  // ----------------------------------
  function automatic cpx_op_t decode(input logic [15:0] w);
    cpx_op_t op;
    op = CPX_NONE;
    if (w[`F_OP6] == `OPC_LSF) op = CPX_LSF;
    else if (w[`F_OP6] == `OPC_SSF) op = CPX_SSF;
    else if (w[`F_OP8] == `OPC_BSET) op = CPX_BSET;
    else if (w[`F_OP8] == `OPC_BCLR) op = CPX_BCLR;
    else if (w[`F_OP8] == `OPC_BTST) op = CPX_BTST;
    else if (w[`F_OP4] == `OPC_JUMP) op = CPX_JUMP;
    else if (w[`F_OP8] == `OPC_SHL) op = CPX_SHL;
    else if (w[`F_OP8] == `OPC_SHRA) op = CPX_SHRA;
    else if (w[`F_OP8] == `OPC_ROR) op = CPX_ROR;
    else if (w[`F_OP8] == `OPC_SHRL) op = CPX_SHRL;
    else if (w[`F_OP11] == `OPC_ILD) op = CPX_ILD;
    else if (w[`F_OP11] == `OPC_IADD) op = CPX_IADD;
    else if (w[`F_OP11] == `OPC_IAND) op = CPX_IAND;
    else if (w[`F_OP11] == `OPC_IOR) op = CPX_IOR;
    else if (w[`F_OP11] == `OPC_ICMP) op = CPX_ICMP;
    return op;
  endfunction

  function automatic logic jump_ok(input logic [3:0] c, input cpx_flags_t f);
    logic ok;
    ok = 1'b0;
    unique case (c)
      `J_ALW: ok = 1'b1;
      `J_LT: ok = !f.agt && !f.eq;
      `J_LE: ok = !f.lgt || f.eq;
      `J_EQ: ok = f.eq;
      `J_HE: ok = f.lgt || f.eq;
      `J_GT: ok = f.agt;
      `J_NE: ok = !f.eq;
      `J_L: ok = !f.lgt && !f.eq;
      `J_H: ok = f.lgt && !f.eq;
      `J_NC: ok = !f.car;
      `J_OC: ok = f.car;
      `J_NO: ok = !f.ovf;
      `J_OP: ok = f.par;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // lgt, agt, eq of a against b
  function automatic logic [2:0] cmp3(input logic [15:0] a, input logic [15:0] b);
    return {a > b, $signed(a) > $signed(b), a == b};
  endfunction

  function automatic logic [4:0] cnt16(input logic [3:0] c);
    return (c == 4'h0) ? `FULL_CNT : {1'b0, c};
  endfunction

  function automatic logic [15:0] wm(input logic [15:0] old, input logic [31:0] d,
                                     input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // carry out and shifted word, one place
  function automatic logic [16:0] shift1(input cpx_op_t op, input logic [15:0] v);
    logic [16:0] r;
    r = {v[0], 1'b0, v[15:1]};
    if (op == CPX_SHL) r = {v[15], v[14:0], 1'b0};
    else if (op == CPX_SHRA) r = {v[0], v[15], v[15:1]};
    else if (op == CPX_ROR) r = {v[0], v[0], v[15:1]};
    return r;
  endfunction

  // ----------------------------------
  // state
  // ----------------------------------
  cpx_state_t state_q, state_d;
  cpx_op_t op_q, op_d;
  cpx_flags_t st_q, st_d;
  cpx_sio_t sio_q, sio_d;
  logic [15:0] ins_q, ins_d, pc_q, pc_d, opnd_q, opnd_d, base_q, base_d;
  logic [15:0] shc_q, shc_d, imm_q, imm_d, res_q, res_d;
  logic [4:0] idx_q, idx_d, total_q, total_d;
  logic sbyte_q, sbyte_d, acc_q, acc_d;
  logic [1:0] sincr_q, sincr_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  // ----------------------------------
  // helpers
  // ----------------------------------
  logic wr_fire, wr_ok, last, sh_c, jmp_ok_w;
  logic [7:0] wr_ofs, rd_ofs;
  logic [4:0] idx_n;
  logic [15:0] sh_v, ssf_res, ser_val, ser_cmp, pc_next, jmp_tgt;
  logic [16:0] add_sum;
  logic [11:0] base_addr, disp_ext;
  cpx_op_t op_dec;

  assign wr_ofs = i_awaddr[`F_ADDR];
  assign rd_ofs = i_araddr[`F_ADDR];
  assign wr_fire = i_awvalid && i_wvalid && !bvalid_q;
  assign wr_ok = wr_ofs inside {`OF_INSTR, `OF_PC, `OF_STAT, `OF_OPND, `OF_BASE,
                                `OF_SHCNT, `OF_IMM};
  assign last = (idx_q == total_q - `ONE_CNT);
  assign idx_n = idx_q + `ONE_CNT;
  assign op_dec = decode(ins_q);
  assign base_addr = base_q[`F_BASE];
  assign disp_ext = 12'($signed(ins_q[`F_DISP]));
  assign {sh_c, sh_v} = shift1(op_q, res_q);
  assign ssf_res = res_q | (16'(i_sio_in) << idx_q[3:0]);
  assign ser_val = (op_q == CPX_LSF) ? opnd_q : ssf_res;
  assign ser_cmp = sbyte_q ? {ser_val[7:0], `ZERO8} : ser_val;
  assign add_sum = {1'b0, opnd_q} + {1'b0, imm_q};
  assign pc_next = pc_q + `WSTEP;
  assign jmp_tgt = pc_next + 16'($signed({ins_q[`F_DISP], 1'b0}));
  assign jmp_ok_w = jump_ok(ins_q[`F_JC], st_q);

  // ----------------------------------
  // axi4-lite slave
  // ----------------------------------
  always_comb begin
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (bvalid_q && i_bready) bvalid_d = 1'b0;
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d = wr_ok ? `RESP_OK : `RESP_ERR;
    end
    if (rvalid_q && i_rready) rvalid_d = 1'b0;
    if (i_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = `RESP_OK;
      unique case (rd_ofs)
        `OF_INSTR: rdata_d = 32'(ins_q);
        `OF_PC: rdata_d = 32'(pc_q);
        `OF_STAT: rdata_d = 32'({st_q, 10'h000});
        `OF_OPND: rdata_d = 32'(opnd_q);
        `OF_BASE: rdata_d = 32'(base_q);
        `OF_SHCNT: rdata_d = 32'(shc_q);
        `OF_IMM: rdata_d = 32'(imm_q);
        `OF_RES: rdata_d = 32'(res_q);
        `OF_CTRL: rdata_d = 32'({sincr_q, sbyte_q, o_busy});
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = `RESP_ERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OK;
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OK;
      rdata_q <= 32'h00000000;
    end else begin
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_awready = wr_fire;
  assign o_wready = wr_fire;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = !rvalid_q;
  assign o_rvalid = rvalid_q;
  assign o_rresp = rresp_q;
  assign o_rdata = rdata_q;

  // ----------------------------------
  // execution
  // ----------------------------------
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    ins_d = ins_q;
    pc_d = pc_q;
    st_d = st_q;
    opnd_d = opnd_q;
    base_d = base_q;
    shc_d = shc_q;
    imm_d = imm_q;
    res_d = res_q;
    idx_d = idx_q;
    total_d = total_q;
    sio_d = sio_q;
    sbyte_d = sbyte_q;
    sincr_d = sincr_q;
    acc_d = acc_q;
    unique case (state_q)
      CPX_IDLE: begin
        // writes while busy are dropped so operands stay put
        if (wr_fire) begin
          unique case (wr_ofs)
            `OF_INSTR: begin
              ins_d = wm(ins_q, i_wdata, i_wstrb);
              state_d = CPX_LOAD;
            end
            `OF_PC: pc_d = wm(pc_q, i_wdata, i_wstrb);
            `OF_STAT: if (i_wstrb[1]) st_d = cpx_flags_t'(i_wdata[`F_ST]);
            `OF_OPND: opnd_d = wm(opnd_q, i_wdata, i_wstrb);
            `OF_BASE: base_d = wm(base_q, i_wdata, i_wstrb);
            `OF_SHCNT: shc_d = wm(shc_q, i_wdata, i_wstrb);
            `OF_IMM: imm_d = wm(imm_q, i_wdata, i_wstrb);
            default: ;
          endcase
        end
      end
      CPX_LOAD: begin
        op_d = op_dec;
        state_d = CPX_RUN;
        idx_d = 5'h00;
        total_d = `ONE_CNT;
        res_d = opnd_q;
        acc_d = 1'b0;
        sbyte_d = 1'b0;
        sincr_d = 2'h0;
        sio_d = '0;
        if (op_dec == CPX_LSF || op_dec == CPX_SSF) begin
          total_d = cnt16(ins_q[`F_SCNT]);
          sbyte_d = (total_d <= `BYTE_MAX);
          if (ins_q[`F_TS] == `TS_AUTO)
            sincr_d = sbyte_d ? `INC_BYTE : `INC_WORD;
          sio_d.addr = base_addr;
          sio_d.data = opnd_q[0];
          sio_d.we = (op_dec == CPX_LSF);
          if (op_dec == CPX_SSF) res_d = `ZERO16;
        end else if (op_dec inside {CPX_BSET, CPX_BCLR, CPX_BTST}) begin
          sio_d.addr = base_addr + disp_ext;
          sio_d.data = (op_dec == CPX_BSET);
          sio_d.we = (op_dec != CPX_BTST);
        end else if (op_dec inside {CPX_SHL, CPX_SHRA, CPX_ROR, CPX_SHRL}) begin
          total_d = (ins_q[`F_SHCNT] == 4'h0) ? cnt16(shc_q[`F_SHN])
                                               : cnt16(ins_q[`F_SHCNT]);
        end
      end
      CPX_RUN: begin
        unique case (op_q)
          CPX_LSF, CPX_SSF: begin
            if (op_q == CPX_SSF) res_d = ssf_res;
            if (last) begin
              sio_d.we = 1'b0;
              {st_d.lgt, st_d.agt, st_d.eq} = cmp3(ser_cmp, `ZERO16);
              st_d.par = sbyte_q && ^ser_val[7:0];
              pc_d = pc_next;
              state_d = CPX_IDLE;
            end else begin
              idx_d = idx_n;
              sio_d.addr = sio_q.addr + 12'h001;
              sio_d.data = opnd_q[idx_n[3:0]];
            end
          end
          CPX_BSET, CPX_BCLR, CPX_BTST: begin
            sio_d.we = 1'b0;
            if (op_q == CPX_BTST) st_d.eq = i_sio_in;
            pc_d = pc_next;
            state_d = CPX_IDLE;
          end
          CPX_JUMP: begin
            pc_d = jmp_ok_w ? jmp_tgt : pc_next;
            state_d = CPX_IDLE;
          end
          CPX_SHL, CPX_SHRA, CPX_ROR, CPX_SHRL: begin
            // one place per cycle keeps the shifter small
            res_d = sh_v;
            st_d.car = sh_c;
            acc_d = acc_q || (op_q == CPX_SHL && res_q[15] != res_q[14]);
            idx_d = idx_n;
            if (last) begin
              {st_d.lgt, st_d.agt, st_d.eq} = cmp3(sh_v, `ZERO16);
              if (op_q == CPX_SHL) st_d.ovf = acc_d;
              pc_d = pc_next;
              state_d = CPX_IDLE;
            end
          end
          CPX_ILD, CPX_IADD, CPX_IAND, CPX_IOR, CPX_ICMP: begin
            unique case (op_q)
              CPX_ILD: res_d = imm_q;
              CPX_IADD: res_d = add_sum[15:0];
              CPX_IAND: res_d = opnd_q & imm_q;
              CPX_IOR: res_d = opnd_q | imm_q;
              default: res_d = opnd_q;
            endcase
            if (op_q == CPX_ICMP) {st_d.lgt, st_d.agt, st_d.eq} = cmp3(opnd_q, imm_q);
            else {st_d.lgt, st_d.agt, st_d.eq} = cmp3(res_d, `ZERO16);
            if (op_q == CPX_IADD) begin
              st_d.car = add_sum[16];
              st_d.ovf = (opnd_q[15] == imm_q[15]) && (add_sum[15] != opnd_q[15]);
            end
            pc_d = pc_q + `ISTEP;
            state_d = CPX_IDLE;
          end
          CPX_NONE: begin
            pc_d = pc_next;
            state_d = CPX_IDLE;
          end
        endcase
      end
      default: state_d = CPX_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_q <= CPX_IDLE;
      op_q <= CPX_NONE;
      ins_q <= `ZERO16;
      pc_q <= `ZERO16;
      st_q <= '0;
      opnd_q <= `ZERO16;
      base_q <= `ZERO16;
      shc_q <= `ZERO16;
      imm_q <= `ZERO16;
      res_q <= `ZERO16;
      idx_q <= 5'h00;
      total_q <= 5'h00;
      sio_q <= '0;
      sbyte_q <= 1'b0;
      sincr_q <= 2'h0;
      acc_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      ins_q <= ins_d;
      pc_q <= pc_d;
      st_q <= st_d;
      opnd_q <= opnd_d;
      base_q <= base_d;
      shc_q <= shc_d;
      imm_q <= imm_d;
      res_q <= res_d;
      idx_q <= idx_d;
      total_q <= total_d;
      sio_q <= sio_d;
      sbyte_q <= sbyte_d;
      sincr_q <= sincr_d;
      acc_q <= acc_d;
    end
  end

  assign o_sio = sio_q;
  assign o_flags = st_q;
  assign o_busy = (state_q != CPX_IDLE);
  assign o_src_byte = sbyte_q;
  assign o_src_incr = sincr_q;

  // ----------------------------------
  // assertions
  // ----------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_load(cpx_op_t o);
    state_q == CPX_LOAD && op_dec == o;
  endsequence
  sequence s_ser_load;
    state_q == CPX_LOAD && op_dec inside {CPX_LSF, CPX_SSF};
  endsequence
  sequence s_run(cpx_op_t o);
    state_q == CPX_RUN && op_q == o;
  endsequence

  a_serial_full: assert property (s_ser_load and ins_q[`F_SCNT] == 4'h0
    |=> total_q == `FULL_CNT) else $error("zero serial count not sixteen");
  a_serial_start: assert property (s_load(CPX_LSF)
    |=> o_sio.we && o_sio.addr == $past(base_q[`F_BASE]) && o_sio.data == $past(opnd_q[0]))
    else $error("serial start address wrong");
  a_base_kept: assert property (state_q == CPX_RUN |=> $stable(base_q))
    else $error("base register changed");
  a_addr_step: assert property (s_run(CPX_LSF) and !last
    |=> o_sio.addr == 12'($past(o_sio.addr) + 12'h001)) else $error("serial address no step");
  a_src_incr: assert property (s_ser_load and ins_q[`F_TS] == `TS_AUTO
    |=> o_src_incr == (total_q <= `BYTE_MAX ? `INC_BYTE : `INC_WORD) && o_src_byte ==
        (total_q <= `BYTE_MAX)) else $error("source step wrong");
  a_bit_set: assert property (s_load(CPX_BSET) ##1 s_run(CPX_BSET)
    |-> o_sio.we && o_sio.data && $stable(st_q)) else $error("bit set failed");
  a_test_eq: assert property (s_run(CPX_BTST) |=> st_q.eq == $past(i_sio_in))
    else $error("bit test flag wrong");
  a_jump_pc: assert property (s_run(CPX_JUMP)
    |=> pc_q == ($past(jmp_ok_w) ? $past(jmp_tgt) : 16'($past(pc_q) + `WSTEP)))
    else $error("jump pc wrong");
  a_imm_pc: assert property (state_q == CPX_RUN && op_q inside {CPX_ILD, CPX_IADD, CPX_ICMP}
    |=> pc_q == 16'($past(pc_q) + `ISTEP)) else $error("immediate pc wrong");
  a_shift_cnt: assert property (state_q == CPX_LOAD && op_dec == CPX_SHRL &&
    ins_q[`F_SHCNT] == 4'h0 && shc_q[`F_SHN] == 4'h0 |=> total_q == `FULL_CNT)
    else $error("shift count not sixteen");
  a_word_par: assert property (s_run(CPX_LSF) and last and total_q > `BYTE_MAX
    |=> !st_q.par) else $error("parity set on word transfer");

endmodule
`default_nettype wire

// ---- verif/cpx_sio_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------
// serial io peripherals
// ----------------------------------
module cpx_sio_model
  import cpx_pkg::*;
(
  // clock
  input wire logic i_ref_clk,
  // serial side
  input wire cpx_pkg::cpx_sio_t i_sio,
  output logic o_bit
);
  // preload a pattern so a stuck input never reads as a match
  logic mem [4096];
  initial begin
    for (int a = 0; a < 4096; a++) begin
      mem[a] = a[0] ^ a[2];
    end
  end
  always @(posedge i_ref_clk) begin
    if (i_sio.we) begin
      mem[i_sio.addr] <= i_sio.data;
    end
  end
  // input bit answers the address shown in the same cycle
  assign o_bit = mem[i_sio.addr];
endmodule
`default_nettype wire

// ---- verif/cpu_io_jump_shift_imm_exec_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cpx_cfg.svh"
module cpu_io_jump_shift_imm_exec_test;
  import cpx_pkg::*;
  // ----------------------------------
  // wiring
  // ----------------------------------
  logic clk;
  logic rst;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, sio_in, busy, src_byte;
  logic [1:0] bresp, rresp, src_incr, resp;
  logic [15:0] rd_val, tgt;
  cpx_sio_t sio;
  cpx_flags_t flags;
  int n_mismatch = 0;
  int check_count = 0;
  logic [15:0] st [3] = '{16'h0000, 16'hFC00, 16'h8000};
  logic [7:0] dsp [3] = '{8'h80, 8'h7F, 8'h01};
  // instr, opnd, count or imm, result, status, pc
  logic [15:0] tab [13][6] = '{
    '{{`OPC_SHL, 8'h20}, 16'h4000, 16'h0000, 16'h0000, 16'h3C00, 16'h0102},
    '{{`OPC_SHL, 8'h10}, 16'h0001, 16'h0000, 16'h0002, 16'hC400, 16'h0102},
    '{{`OPC_SHRA, 8'h00}, 16'h8001, 16'h0000, 16'hFFFF, 16'h9C00, 16'h0102},
    '{{`OPC_SHRL, 8'h00}, 16'h000D, 16'hFFF3, 16'h0001, 16'hDC00, 16'h0102},
    '{{`OPC_ROR, 8'h40}, 16'h1234, 16'h0000, 16'h4123, 16'hCC00, 16'h0102},
    '{{`OPC_IADD, 5'h00}, 16'h7FFF, 16'h0001, 16'h8000, 16'h8C00, 16'h0104},
    '{{`OPC_IADD, 5'h00}, 16'hFFFF, 16'h0001, 16'h0000, 16'h3400, 16'h0104},
    '{{`OPC_IAND, 5'h00}, 16'hF0F0, 16'h0FF0, 16'h00F0, 16'hDC00, 16'h0104},
    '{{`OPC_IOR, 5'h00}, 16'h00F0, 16'h0F00, 16'h0FF0, 16'hDC00, 16'h0104},
    '{{`OPC_ILD, 5'h00}, 16'h1234, 16'h8000, 16'h8000, 16'h9C00, 16'h0104},
    '{{`OPC_ICMP, 5'h00}, 16'hFFFF, 16'h0001, 16'hFFFF, 16'h9C00, 16'h0104},
    '{{`OPC_ICMP, 5'h00}, 16'h0005, 16'h0005, 16'h0005, 16'h3C00, 16'h0104},
    '{16'h0000, 16'h1234, 16'h0000, 16'h1234, 16'h1C00, 16'h0102}}; // unknown code, no-op

  cpx_exec i_cpx_exec (.i_ref_clk(clk), .i_rst(rst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_sio(sio), .i_sio_in(sio_in), .o_flags(flags),
    .o_busy(busy), .o_src_byte(src_byte), .o_src_incr(src_incr));
  cpx_sio_model i_cpx_sio_model (.i_ref_clk(clk), .i_sio(sio), .o_bit(sio_in));

  // ----------------------------------
  // bus tasks
  // ----------------------------------
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rd_val = rdata[15:0];
    resp = rresp;
    rready <= 1'b0;
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk(nm, e, rd_val);
  endtask
  // leaves the last control word in rd_val
  task run(input logic [15:0] ins);
    int n;
    n = 0;
    wr(`OF_INSTR, ins);
    rd(`OF_CTRL);
    while (rd_val[0] !== 1'b0 && n < 200) begin
      rd(`OF_CTRL);
      n++;
    end
    chk("busy", 16'h0000, {15'h0000, rd_val[0]});
  endtask
  function automatic logic jt(input logic [3:0] c, input logic [15:0] f);
    case (c)
      `J_ALW: jt = 1'b1;
      `J_LT: jt = !f[14] && !f[13];
      `J_LE: jt = !f[15] || f[13];
      `J_EQ: jt = f[13];
      `J_HE: jt = f[15] || f[13];
      `J_GT: jt = f[14];
      `J_NE: jt = !f[13];
      `J_NC: jt = !f[12];
      `J_OC: jt = f[12];
      `J_NO: jt = !f[11];
      `J_L: jt = !f[15] && !f[13];
      `J_H: jt = f[15] && !f[13];
      `J_OP: jt = f[10];
      default: jt = 1'b0;
    endcase
  endfunction
  task end_of_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------
  // tests
  // ----------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // whole run needs about twelve hundred cycles
  initial begin
    #3000000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr(`OF_RES, 16'h1234);
    chk("ro bresp", {14'h0000, `RESP_ERR}, {14'h0000, resp});
    rd(8'h24);
    chk("unmapped rresp", {14'h0000, `RESP_ERR}, {14'h0000, resp});
    wr(`OF_BASE, 16'h0020);
    wr(`OF_OPND, 16'h000D);
    run({`OPC_LSF, 4'h2, `TS_AUTO, 4'h0});
    chk("src mode", 16'h0006, rd_val);
    for (int i = 0; i < 3; i++) begin
      chk("sio out", {15'h0000, i == 0}, {15'h0000, i_cpx_sio_model.mem[16 + i]});
    end
    rchk("base kept", `OF_BASE, 16'h0020);
    rchk("load flags", `OF_STAT, 16'hC400);
    chk("src pins", 16'h0006, {12'h000, src_incr, src_byte, busy});
    run({`OPC_LSF, 4'h0, 2'h0, 4'h0});
    chk("word mode", 16'h0000, rd_val);
    for (int i = 0; i < 16; i++) begin
      tgt[i] = i_cpx_sio_model.mem[16 + i];
    end
    chk("sio word", 16'h000D, tgt);
    rchk("word flags", `OF_STAT, 16'hC000);
    wr(`OF_BASE, 16'h0200);
    for (int k = 0; k < 2; k++) begin
      run({`OPC_SSF, k ? 4'hB : 4'h0, `TS_AUTO, 4'h0});
      chk("src mode", 16'h0008, rd_val);
      rchk("stored", `OF_RES, k ? 16'h025A : 16'h5A5A);
      rchk("store flags", `OF_STAT, 16'hC000);
    end
    for (int k = 0; k < 2; k++) begin
      run({k ? `OPC_BSET : `OPC_BCLR, 8'hFE});
      chk("sio bit", {15'h0000, k[0]}, {15'h0000, i_cpx_sio_model.mem[254]});
      rchk("flags kept", `OF_STAT, 16'hC000);
      run({`OPC_BTST, 8'hFE});
      rchk("bit test", `OF_STAT, k ? 16'hE000 : 16'hC000);
    end
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 13; c++) begin
        wr(`OF_STAT, st[s]);
        wr(`OF_PC, 16'h0400);
        run({`OPC_JUMP, c[3:0], dsp[s]});
        tgt = 16'h0402 + {{7{dsp[s][7]}}, dsp[s], 1'b0};
        rchk("jump pc", `OF_PC, jt(c[3:0], st[s]) ? tgt : 16'h0402);
      end
    end
    wr(`OF_STAT, 16'h1C00);
    for (int i = 0; i < 13; i++) begin
      wr(`OF_OPND, tab[i][1]);
      wr(`OF_SHCNT, tab[i][2]);
      wr(`OF_IMM, tab[i][2]);
      wr(`OF_STAT, 16'h1C00);
      wr(`OF_PC, 16'h0100);
      run(tab[i][0]);
      rchk("result", `OF_RES, tab[i][3]);
      rchk("status", `OF_STAT, tab[i][4]);
      chk("flag pins", tab[i][4], {flags, 10'h000});
      rchk("next pc", `OF_PC, tab[i][5]);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
